// [src/mad_host.sv]
// Purpose: Bus master end: holds a slot table of module addresses, checks
//          it for clashes and polls each configured module in turn.
// Assumes: Register port strobes are one cycle; read data the cycle after.
// Notes:   A poll waits a bounded time for each answer.
`default_nettype none

module mad_host #(
    // Table depth
    parameter int unsigned NUM_SLOTS = 32,
    // Build: 8 or 4 lines
    parameter int unsigned LINES = 8,
    // Answer wait in cycles
    parameter int unsigned RSP_WAIT = mad_pkg::RSP_WAIT_CYC
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Status
    output logic poll_busy,
    output logic cfg_error,
    // Link to modules
    mad_link_if.host link
);

    // Accepted module limit for this build
    localparam logic [5:0] MAX_MODS = 6'((LINES == 8) ? mad_pkg::MAX_MOD_8LINE
                                                    : mad_pkg::MAX_MOD_4LINE);

    // Poll sequencer states
    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} mad_host_fsm_t;

    // All state of the module
    typedef struct packed {
        logic [NUM_SLOTS-1:0][7:0] slot;  // Valid, analog, address
        logic [NUM_SLOTS-1:0] seen;       // Answer received per slot
        logic [5:0] count;                // Slots to poll
        logic [7:0] cmd;                  // Command byte sent
        logic err;                        // Clash or bad address, sticky
        logic refused;                    // Start refused, sticky
        mad_host_fsm_t fsm;               // Sequencer
        logic [5:0] idx;                  // Current slot
        logic [7:0] timer;                // Answer wait
        logic req_valid;                  // Request strobe
        logic [5:0] req_addr;             // Request address
        logic [31:0] rdata;               // Read data
    } mad_host_state_t;

    mad_host_state_t st;       // Registered state
    mad_host_state_t next_st;  // Next state

    logic [7:0] sdiff;         // Offset into the slot window
    logic [5:0] widx;          // Addressed slot
    logic slot_hit;            // Access lands in the slot window
    logic [7:0] cur;           // Current slot entry

    // Next-state logic
    always_comb begin
        next_st = st;
        sdiff = reg_addr - mad_pkg::REG_SLOT_BASE;
        widx = sdiff[7:2];
        slot_hit = (reg_addr >= mad_pkg::REG_SLOT_BASE) && (sdiff[1:0] == 2'b00) &&
                   (widx < 6'(NUM_SLOTS));
        cur = st.slot[st.idx[4:0]];
        next_st.req_valid = 1'b0;
        next_st.rdata = '0;

        // Register reads, data in the following cycle
        if (reg_rd) begin
            if (reg_addr == mad_pkg::REG_CTRL) begin
                next_st.rdata[mad_pkg::CTRL_COUNT_LSB +: 6] = st.count;
                next_st.rdata[mad_pkg::CTRL_CMD_LSB +: 8] = st.cmd;
            end else if (reg_addr == mad_pkg::REG_STATUS) begin
                next_st.rdata[mad_pkg::STAT_BUSY_BIT] = (st.fsm != H_IDLE);
                next_st.rdata[mad_pkg::STAT_ERR_BIT] = st.err;
                next_st.rdata[mad_pkg::STAT_REFUSED_BIT] = st.refused;
            end else if (reg_addr == mad_pkg::REG_SEEN) begin
                next_st.rdata[NUM_SLOTS-1:0] = st.seen;
            end else if (slot_hit) begin
                next_st.rdata[7:0] = st.slot[widx[4:0]];
            end
        end

        // Error and refused status flags clear on write of one
        if (reg_wr && reg_addr == mad_pkg::REG_STATUS) begin
            if (reg_wdata[mad_pkg::STAT_ERR_BIT]) begin
                next_st.err = 1'b0;
            end
            if (reg_wdata[mad_pkg::STAT_REFUSED_BIT]) begin
                next_st.refused = 1'b0;
            end
        end

        // Slot write with range and clash checks, a set beats a clear
        if (reg_wr && slot_hit && st.fsm == H_IDLE) begin
            next_st.slot[widx[4:0]] = reg_wdata[7:0];
            if (reg_wdata[mad_pkg::SLOT_VALID_BIT]) begin
                if (reg_wdata[5:0] < mad_pkg::ADDR_MIN ||
                    mad_pkg::block_end(reg_wdata[5:0], reg_wdata[mad_pkg::SLOT_ANALOG_BIT])
                    > mad_pkg::ADDR_END) begin
                    next_st.err = 1'b1;
                end
                for (int j = 0; j < NUM_SLOTS; j++) begin
                    if (j != int'(widx) && st.slot[j][mad_pkg::SLOT_VALID_BIT] &&
                        mad_pkg::blocks_overlap(reg_wdata[5:0],
                                                reg_wdata[mad_pkg::SLOT_ANALOG_BIT],
                                                st.slot[j][5:0],
                                                st.slot[j][mad_pkg::SLOT_ANALOG_BIT])) begin
                        next_st.err = 1'b1;
                    end
                end
            end
        end

        // Poll sequencer
        unique case (st.fsm)
            H_IDLE: begin
                if (reg_wr && reg_addr == mad_pkg::REG_CTRL) begin
                    next_st.count = reg_wdata[mad_pkg::CTRL_COUNT_LSB +: 6];
                    next_st.cmd = reg_wdata[mad_pkg::CTRL_CMD_LSB +: 8];
                    if (reg_wdata[mad_pkg::CTRL_START_BIT]) begin
                        // Too many modules or a bad table refuses the start
                        if (reg_wdata[mad_pkg::CTRL_COUNT_LSB +: 6] > MAX_MODS ||
                            reg_wdata[mad_pkg::CTRL_COUNT_LSB +: 6] > 6'(NUM_SLOTS) ||
                            st.err) begin
                            next_st.refused = 1'b1;
                        end else begin
                            next_st.fsm = H_ISSUE;
                            next_st.idx = '0;
                        end
                    end
                end
            end
            H_ISSUE: begin
                // End of table or next configured slot
                if (st.idx >= st.count) begin
                    next_st.fsm = H_IDLE;
                end else if (cur[mad_pkg::SLOT_VALID_BIT]) begin
                    next_st.req_valid = 1'b1;
                    next_st.req_addr = cur[5:0];
                    next_st.timer = '0;
                    next_st.fsm = H_WAIT;
                end else begin
                    next_st.seen[st.idx[4:0]] = 1'b0;
                    next_st.idx = st.idx + 6'h01;
                end
            end
            H_WAIT: begin
                // Matching answer or timeout closes the slot
                if (link.rsp_valid && link.rsp_addr == st.req_addr) begin
                    next_st.seen[st.idx[4:0]] = 1'b1;
                    next_st.idx = st.idx + 6'h01;
                    next_st.fsm = H_ISSUE;
                end else if (st.timer == 8'(RSP_WAIT - 1)) begin
                    next_st.seen[st.idx[4:0]] = 1'b0;
                    next_st.idx = st.idx + 6'h01;
                    next_st.fsm = H_ISSUE;
                end else begin
                    next_st.timer = st.timer + 8'h01;
                end
            end
        endcase
    end

    // State register with clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.count <= mad_pkg::RST_COUNT;
            st.cmd <= mad_pkg::RST_CMD;
            st.fsm <= H_IDLE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign reg_rdata = st.rdata;
    assign poll_busy = (st.fsm != H_IDLE);
    assign cfg_error = st.err;
    assign link.req_valid = st.req_valid;
    assign link.req_addr = st.req_addr;
    assign link.req_cmd = st.cmd;

endmodule : mad_host

`default_nettype wire

// [src/mad_pkg.sv]
// Purpose: Shared constants, field layouts and decode helpers for the
//          module address switch decode link (field module and bus master).
// Assumes: One 50 MHz clock on both ends, synchronous active-high reset.
// Notes:   Address values are plain binary, 1 to 32, held in six bits.
`default_nettype none

package mad_pkg;

    // Address space
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned SW_W = 5;
    localparam int unsigned CMD_W = 8;
    localparam logic [5:0] ADDR_MIN = 6'h01;
    localparam logic [6:0] ADDR_END = 7'h21;
    localparam logic [5:0] ALL_OFF_ADDR = 6'h20;
    localparam logic [5:0] ANALOG_SPAN = 6'h08;
    localparam logic [5:0] SINGLE_SPAN = 6'h01;

    // Module count limits per build
    localparam int unsigned MAX_MOD_8LINE = 32;
    localparam int unsigned MAX_MOD_4LINE = 16;

    // Master register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SEEN = 8'h08;
    localparam logic [7:0] REG_SLOT_BASE = 8'h40;

    // Master register fields
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_COUNT_LSB = 8;
    localparam int unsigned CTRL_CMD_LSB = 16;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_ERR_BIT = 1;
    localparam int unsigned STAT_REFUSED_BIT = 2;
    localparam int unsigned SLOT_ANALOG_BIT = 6;
    localparam int unsigned SLOT_VALID_BIT = 7;

    // Values after reset
    localparam logic [5:0] RST_COUNT = 6'h00;
    localparam logic [7:0] RST_CMD = 8'h00;
    localparam logic [6:0] RST_PINS = 7'h00;

    // Timing
    localparam int unsigned CLK_NS = 20;
    localparam int unsigned RSP_WAIT_NS = 320;
    localparam int unsigned RSP_WAIT_CYC = RSP_WAIT_NS / CLK_NS;

    // Switch bank to address, all off reads as the top address
    function automatic logic [5:0] decode_addr(input logic [4:0] sw);
        return (sw == 5'h00) ? ALL_OFF_ADDR : {1'b0, sw};
    endfunction : decode_addr

    // One past the last address of a block
    function automatic logic [6:0] block_end(input logic [5:0] base, input logic analog);
        return {1'b0, base} + {1'b0, (analog ? ANALOG_SPAN : SINGLE_SPAN)};
    endfunction : block_end

    // Address falls inside a block
    function automatic logic in_block(input logic [5:0] a, input logic [5:0] base,
                                      input logic analog);
        return (a >= base) && ({1'b0, a} < block_end(base, analog));
    endfunction : in_block

    // Two blocks share any address
    function automatic logic blocks_overlap(input logic [5:0] a, input logic a_an,
                                            input logic [5:0] b, input logic b_an);
        return in_block(a, b, b_an) || in_block(b, a, a_an);
    endfunction : blocks_overlap

endpackage : mad_pkg

`default_nettype wire

// [src/mad_link_if.sv]
// Purpose: Frame-level link between the bus master and one field module.
// Assumes: Both ends run on the same clock; signals are plain levels.
// Notes:   A request stands one cycle; an answer stands one cycle.
`default_nettype none

interface mad_link_if;

    // Master to module
    logic req_valid;
    logic [5:0] req_addr;
    logic [7:0] req_cmd;
    // Module to master
    logic rsp_valid;
    logic [5:0] rsp_addr;
    logic [7:0] rsp_data;

    // Field module end
    modport device (
        input req_valid, req_addr, req_cmd,
        output rsp_valid, rsp_addr, rsp_data
    );

    // Bus master end
    modport host (
        output req_valid, req_addr, req_cmd,
        input rsp_valid, rsp_addr, rsp_data
    );

endinterface : mad_link_if

`default_nettype wire

// [src/mad_device.sv]
// Purpose: Field module end: reads the address switch bank, decodes the
//          slave address, drives line termination and answers frames.
// Assumes: Switch and jumper pins are asynchronous; link is same-clock logic.
// Notes:   Fill and delay option switches have no input here at all.
`default_nettype none

module mad_device #(
    // Board carries eight analog inputs and a termination jumper
    parameter bit ANALOG_BOARD = 1'b0
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Configuration pins
    input wire logic [4:0] addr_switch,
    input wire logic line_termination_switch,
    input wire logic term_jumper,
    // Link to the master
    mad_link_if.device link,
    // User side
    output logic [5:0] slave_addr,
    output logic term_enable,
    output logic addr_changed,
    output logic block_fault,
    output logic cmd_valid,
    output logic [7:0] cmd_data,
    output logic [2:0] cmd_channel,
    input wire logic [7:0] rsp_byte
);

    // Pin bit positions inside the synchroniser vector
    localparam int unsigned PIN_TERM = 5;
    localparam int unsigned PIN_JUMP = 6;

    // All state of the module
    typedef struct packed {
        logic [6:0] s1;         // First synchroniser stage
        logic [6:0] s2;         // Second stage
        logic [6:0] s3;         // Third stage
        logic [6:0] pins;       // Accepted pin levels
        logic [5:0] addr;       // Decoded slave address
        logic term;             // Termination drive
        logic changed;          // Address moved pulse
        logic fault;            // Block runs past the top address
        logic rsp_valid;        // Answer strobe
        logic [5:0] rsp_addr;   // Address being answered
        logic [7:0] rsp_data;   // Answer byte
        logic cmd_valid;        // Command strobe to user
        logic [7:0] cmd_data;   // Command byte to user
        logic [2:0] cmd_chan;   // Channel inside the block
    } mad_dev_state_t;

    mad_dev_state_t st;         // Registered state
    mad_dev_state_t next_st;    // Next state

    // Raw pin vector in synchroniser order
    logic [6:0] raw_pins;
    // Address from accepted switch levels
    logic [5:0] dec_addr;
    // Offset of the request inside the owned block
    logic [5:0] req_off;
    // Request hits this module
    logic hit;

    // Pin gathering, option switches six and seven never enter
    assign raw_pins = {term_jumper, line_termination_switch, addr_switch};

    // Next-state logic
    always_comb begin
        next_st = st;
        dec_addr = mad_pkg::decode_addr(st.pins[4:0]);
        req_off = link.req_addr - st.addr;
        hit = 1'b0;

        // Three-stage sampling of the asynchronous pins
        next_st.s1 = raw_pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;

        // Level accepted once the second and third stage agree, bit by bit
        for (int i = 0; i < 7; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.pins[i] = st.s3[i];
            end
        end

        // Address decode from switches one to five
        next_st.addr = dec_addr;
        next_st.changed = (dec_addr != st.addr);

        // An analog block must end at or below the top address
        next_st.fault = ANALOG_BOARD &&
                        (mad_pkg::block_end(dec_addr, 1'b1) > mad_pkg::ADDR_END);

        // Termination from switch eight, or the jumper on an analog board
        if (ANALOG_BOARD) begin
            next_st.term = st.pins[PIN_TERM] | st.pins[PIN_JUMP];
        end else begin
            next_st.term = st.pins[PIN_TERM];
        end

        // Strobes last one cycle
        next_st.rsp_valid = 1'b0;
        next_st.cmd_valid = 1'b0;

        // Address match, a whole block of eight on an analog board
        if (link.req_valid) begin
            hit = mad_pkg::in_block(link.req_addr, st.addr, ANALOG_BOARD);
            // A block past the top is a broken setup, stay silent
            if (st.fault || st.changed) begin
                hit = 1'b0;
            end
        end

        // Answer and hand the command to the user
        if (hit) begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_addr = link.req_addr;
            next_st.rsp_data = rsp_byte;
            next_st.cmd_valid = 1'b1;
            next_st.cmd_data = link.req_cmd;
            next_st.cmd_chan = ANALOG_BOARD ? req_off[2:0] : 3'h0;
        end
    end

    // State register with clock enable
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.s1 <= mad_pkg::RST_PINS;
            st.s2 <= mad_pkg::RST_PINS;
            st.s3 <= mad_pkg::RST_PINS;
            st.pins <= mad_pkg::RST_PINS;
            st.addr <= mad_pkg::ALL_OFF_ADDR;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Link outputs straight from the state
    assign link.rsp_valid = st.rsp_valid;
    assign link.rsp_addr = st.rsp_addr;
    assign link.rsp_data = st.rsp_data;

    // User outputs straight from the state
    assign slave_addr = st.addr;
    assign term_enable = st.term;
    assign addr_changed = st.changed;
    assign block_fault = st.fault;
    assign cmd_valid = st.cmd_valid;
    assign cmd_data = st.cmd_data;
    assign cmd_channel = st.cmd_chan;

endmodule : mad_device

`default_nettype wire

// [tb/mad_link_assertions.sv]
// Purpose: Concurrent checks on the master to module link.
// Assumes: One clock, synchronous active-high reset, device is a single-address board.
// Notes:   Sees only link signals and the device's decode and command outputs.
`default_nettype none

module mad_link_assertions (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Link signals
    input wire logic req_valid,
    input wire logic [5:0] req_addr,
    input wire logic [7:0] req_cmd,
    input wire logic rsp_valid,
    input wire logic [5:0] rsp_addr,
    input wire logic [7:0] rsp_data,
    // Device decode and command outputs
    input wire logic [5:0] slave_addr,
    input wire logic block_fault,
    input wire logic addr_changed,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Request that the device must take
    sequence s_hit;
        req_valid && ce && (req_addr == slave_addr) && !block_fault && !addr_changed;
    endsequence
    // Request for some other address
    sequence s_miss;
        req_valid && (req_addr != slave_addr);
    endsequence

    chk_hit_answered: assert property (s_hit |=> rsp_valid)
        else $error("matching request not answered next cycle");
    chk_miss_silent: assert property (s_miss |=> !rsp_valid)
        else $error("device answered a foreign address");
    chk_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    chk_rsp_addr_echo: assert property (rsp_valid |-> rsp_addr == $past(req_addr))
        else $error("answer carries wrong address");
    chk_cmd_passed: assert property (s_hit |=> cmd_valid && cmd_data == $past(req_cmd))
        else $error("command byte not delivered");
    chk_addr_range: assert property (slave_addr >= 6'h01 && slave_addr <= 6'h20)
        else $error("decoded address outside 1 to 32");
    chk_poll_range: assert property (req_valid |-> req_addr >= 6'h01 && req_addr <= 6'h20)
        else $error("poll address outside 1 to 32");
    chk_req_spacing: assert property (req_valid |=> !req_valid [*2])
        else $error("requests too close together");
    chk_no_fault_single: assert property (!block_fault)
        else $error("block fault on single-address board");

    // Main scenarios seen
    cov_hit: cover property (s_hit ##1 rsp_valid);
    cov_miss: cover property (s_miss);

endmodule : mad_link_assertions

`default_nettype wire

// [tb/module_address_switch_decode_test.sv]
// Purpose: Self-checking bench with master and field module joined by the link.
// Assumes: 50 MHz clock, register strobes one cycle, read data one cycle later.
// Notes:   Answer wait shortened to 4 cycles; device answers in one.
`default_nettype none

module module_address_switch_decode_test;
    timeunit 1ns;
    timeprecision 1ns;

    // Clock and reset
    logic clk = 1'b0;
    logic rst = 1'b1;
    // Device pins
    logic [4:0] addr_switch = 5'h00;
    logic term_sw = 1'b0;
    logic term_jumper = 1'b0;
    logic [7:0] rsp_byte = 8'h3c;
    // Register port
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    // Observed outputs
    logic poll_busy, cfg_error, term_enable, addr_changed, block_fault, cmd_valid;
    logic [5:0] slave_addr;
    logic [7:0] cmd_data;
    logic [2:0] cmd_channel;
    // Tallies
    int mismatches = 0;
    int check_count = 0;

    mad_link_if mad_link_if_inst ();

    mad_device mad_device_inst (
        .clk(clk), .rst(rst), .ce(1'b1), .addr_switch(addr_switch),
        .line_termination_switch(term_sw), .term_jumper(term_jumper),
        .link(mad_link_if_inst.device), .slave_addr(slave_addr), .term_enable(term_enable),
        .addr_changed(addr_changed), .block_fault(block_fault), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_channel(cmd_channel), .rsp_byte(rsp_byte));

    mad_host #(.RSP_WAIT(4)) mad_host_inst (
        .clk(clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .poll_busy(poll_busy),
        .cfg_error(cfg_error), .link(mad_link_if_inst.host));

    mad_link_assertions mad_link_assertions_inst (
        .clk(clk), .rst(rst), .ce(1'b1), .req_valid(mad_link_if_inst.req_valid),
        .req_addr(mad_link_if_inst.req_addr), .req_cmd(mad_link_if_inst.req_cmd),
        .rsp_valid(mad_link_if_inst.rsp_valid), .rsp_addr(mad_link_if_inst.rsp_addr),
        .rsp_data(mad_link_if_inst.rsp_data), .slave_addr(slave_addr),
        .block_fault(block_fault), .addr_changed(addr_changed), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data));

    // Clock generator, 20 ns period
    initial begin
        forever #10 clk = ~clk;
    end

    // Compare one result
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One-cycle register write
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // One-cycle register read, data taken the cycle after
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Slot entry: valid, analog, address
    task automatic set_slot(input int n, input logic an, input logic [5:0] a);
        reg_write(8'h40 + 8'(4 * n), {24'h0000_00, 1'b1, an, a});
    endtask : set_slot

    // Clear all slots used here and the sticky flags
    task automatic clear_cfg();
        for (int n = 0; n < 3; n++) begin
            reg_write(8'h40 + 8'(4 * n), 32'h0000_0000);
        end
        reg_write(8'h04, 32'h0000_0006);
    endtask : clear_cfg

    // Start a poll and wait for it to end
    task automatic run_poll(input logic [5:0] cnt, input logic [7:0] cmd);
        int k;
        reg_write(8'h00, {8'h00, cmd, 2'b00, cnt, 8'h01});
        repeat (3) @(posedge clk);
        #1;
        k = 0;
        while (poll_busy !== 1'b0 && k < 200) begin
            @(posedge clk);
            #1;
            k++;
        end
        check({31'h0, poll_busy}, 32'h0000_0000, "poll end");
    endtask : run_poll

    // Every switch setting decodes as in the table
    task automatic test_decode();
        logic [5:0] exp;
        for (int s = 0; s < 32; s++) begin
            @(posedge clk);
            addr_switch <= 5'(s);
            repeat (8) @(posedge clk);
            exp = (s == 0) ? 6'h20 : 6'(s);
            check({26'h0, slave_addr}, {26'h0, exp}, "decoded address");
        end
        $display("test decode done");
    endtask : test_decode

    // Termination follows switch eight only on a plain board
    task automatic test_term();
        logic [2:0] pat [3] = '{3'b100, 3'b010, 3'b000};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            term_sw <= pat[i][2];
            term_jumper <= pat[i][1];
            repeat (8) @(posedge clk);
            check({31'h0, term_enable}, {31'h0, pat[i][2]}, "termination");
        end
        $display("test termination done");
    endtask : test_term

    // Polls reach only the module at its own address
    task automatic test_poll();
        logic [31:0] d;
        @(posedge clk);
        addr_switch <= 5'h09;
        repeat (8) @(posedge clk);
        set_slot(0, 1'b0, 6'h09);
        run_poll(6'h01, 8'ha5);
        reg_read(8'h08, d);
        check(d, 32'h0000_0001, "seen match");
        check({24'h0, cmd_data}, 32'h0000_00a5, "command byte");
        check({24'h0, mad_link_if_inst.rsp_data}, 32'h0000_003c, "answer byte");
        check({29'h0, cmd_channel}, 32'h0000_0000, "channel on plain board");
        set_slot(0, 1'b0, 6'h0a);
        set_slot(1, 1'b0, 6'h09);
        run_poll(6'h02, 8'h5a);
        reg_read(8'h08, d);
        check(d, 32'h0000_0002, "seen second slot");
        clear_cfg();
        $display("test poll done");
    endtask : test_poll

    // Clashing tables raise the sticky error
    task automatic test_clash();
        logic [31:0] d;
        logic [5:0] b [3] = '{6'h05, 6'h0c, 6'h1e};
        logic an [3] = '{1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 2; i++) begin
            set_slot(0, an[i], 6'h08);
            set_slot(1, 1'b0, (i == 0) ? 6'h08 : b[1]);
            reg_read(8'h04, d);
            check({31'h0, d[1]}, 32'h0000_0001, "overlap error");
            check({31'h0, cfg_error}, 32'h0000_0001, "error pin");
            clear_cfg();
            reg_read(8'h04, d);
            check({31'h0, d[1]}, 32'h0000_0000, "error cleared");
        end
        set_slot(0, an[2], b[2]);
        reg_read(8'h04, d);
        check({31'h0, d[1]}, 32'h0000_0001, "block past top");
        clear_cfg();
        set_slot(0, 1'b1, 6'h08);
        set_slot(1, 1'b0, 6'h10);
        reg_read(8'h04, d);
        check({31'h0, d[1]}, 32'h0000_0000, "adjacent blocks");
        clear_cfg();
        $display("test clash done");
    endtask : test_clash

    // Too many modules refused; unmapped read gives zero
    task automatic test_limit();
        logic [31:0] d;
        run_poll(6'h20, 8'h00);
        reg_read(8'h04, d);
        check({30'h0, d[2], d[0]}, 32'h0000_0000, "count at limit");
        reg_write(8'h00, 32'h0000_2101);
        reg_read(8'h04, d);
        check({30'h0, d[2], d[0]}, 32'h0000_0002, "count refused");
        reg_read(8'h10, d);
        check(d, 32'h0000_0000, "unmapped read");
        $display("test limit done");
    endtask : test_limit

    // Counts and verdict
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        test_decode();
        test_term();
        test_poll();
        test_clash();
        test_limit();
        final_report();
    end

    // Hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #(20 * 20000);
        mismatches++;
        final_report();
    end

endmodule : module_address_switch_decode_test

`default_nettype wire
